// ---- design/fault_protect_consts.vh ----
// Timing and reset constants of the switch fault protection logic
`ifndef FAULT_PROTECT_CONSTS_VH
`define FAULT_PROTECT_CONSTS_VH
`define CLK_PERIOD_NS 20
`define TURNOFF_DELAY_NS 60
`define TURNOFF_DELAY_CYC ((`TURNOFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WINDOW_NS 40
`define WINDOW_CYC ((`WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_NS 200
`define BLANK_CYC ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SC_RESET_CYC 400
`define CNT_W 16
`define SW_NORMAL 2'h0
`define SW_SOFT 2'h1
`endif

// ---- design/power_switch_fault_protect.v ----
// Fault protection, thermal diode emulation and fault reporting logic
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_consts.vh"

module power_switch_fault_protect #(
	parameter SC_RESET_CYCLES = `SC_RESET_CYC,
	parameter CNT_W = `CNT_W
) (
	input wire mclk,
	input wire rst_n,
	input wire gate_cmd,
	input wire oc_cmp,
	input wire sc_cmp,
	input wire fet_hot,
	input wire drv_hot,
	input wire supply_good,
	input wire series_on,
	input wire drive_open,
	input wire neg_drain,
	input wire fwd_current,
	input wire oc_pin_in,
	output reg fet_on_r,
	output reg [1:0] drive_sel_r,
	output reg aux_regulator_en_r,
	output reg negative_rail_en_r,
	output reg fault_n_r,
	output reg fault_oe_r,
	output reg overcurrent_status_n_r,
	output reg overcurrent_status_oe_r,
	output reg combined_mode_r
);
	// Cycle counts arrive as 32-bit integers; keep only the counter width
	localparam integer DLY_I = `TURNOFF_DELAY_CYC;
	localparam integer WIN_I = `WINDOW_CYC;
	localparam integer BLANK_I = `BLANK_CYC;
	localparam integer SCR_I = SC_RESET_CYCLES;
	localparam [CNT_W-1:0] DLY = DLY_I[CNT_W-1:0];
	localparam [CNT_W-1:0] WIN = WIN_I[CNT_W-1:0];
	localparam [CNT_W-1:0] BLANK = BLANK_I[CNT_W-1:0];
	localparam [CNT_W-1:0] SCR = SCR_I[CNT_W-1:0];
	// Diode emulation states
	localparam [1:0] DE_BLANK = 2'h1;
	localparam [1:0] DE_WATCH = 2'h2;
	localparam [1:0] DE_ON = 2'h3;

	// Saturating increment shared by all counters
	function [CNT_W-1:0] inc;
		input [CNT_W-1:0] v;
		begin
			inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// Counter has reached a limit; a limit of one is met on the first cycle.
	// A limit of zero wraps to all ones and fires only once a counter saturates, so every count must be one or more
	function reached;
		input [CNT_W-1:0] v;
		input [CNT_W-1:0] lim;
		begin
			reached = (v >= lim - {{(CNT_W-1){1'b0}}, 1'b1});
		end
	endfunction

	// Two-flop synchronisers for every pin-side input, stage one feeds stage two only
	localparam NS = 12;
	// Bit zero is a constant one: it walks through both stages and marks
	// the first edge at which every synchronised input holds a pin sample
	wire [NS-1:0] raw = {oc_pin_in, fwd_current, neg_drain, drive_open,
		series_on, supply_good, drv_hot, fet_hot, sc_cmp, oc_cmp, gate_cmd,
		1'b1};
	reg [NS-1:0] s1_r;
	reg [NS-1:0] s2_r;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= {NS{1'b0}};
			s2_r <= {NS{1'b0}};
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end
	// Synchronised views of the pins
	wire cmd = s2_r[1];
	wire oc_s = s2_r[2];
	wire sc_s = s2_r[3];
	wire fhot = s2_r[4];
	wire dhot = s2_r[5];
	wire sgood = s2_r[6];
	wire ser_on = s2_r[7];
	wire dopen = s2_r[8];
	wire ndrain = s2_r[9];
	wire fwd = s2_r[10];
	wire ocpin = s2_r[11];
	wire settled = s2_r[0];

	// Internal state
	reg cmd_d_r;
	reg sgood_d_r;
	reg [CNT_W-1:0] oc_cnt_r;
	reg oc_flag_r;
	reg sc_latch_r;
	reg [CNT_W-1:0] low_cnt_r;
	reg [1:0] de_st_r;
	reg [1:0] de_st_nxt;
	reg [CNT_W-1:0] blank_cnt_r;
	reg strap_done_r;
	reg rails_r;

	// Derived conditions
	wire cmd_fall = cmd_d_r & ~cmd;
	wire lockout = ~sgood;
	wire hot = fhot | dhot;
	// Delayed overcurrent reaches the window before short detect wins
	wire oc_win = oc_s && reached(oc_cnt_r, WIN);
	wire oc_off = oc_s && reached(oc_cnt_r, DLY);

	// Edge history of the synchronised command and supply-good
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_d_r <= 1'b0;
			sgood_d_r <= 1'b0;
		end else begin
			cmd_d_r <= cmd;
			sgood_d_r <= sgood;
		end
	end

	// Overcurrent timing and cycle flag; a short that shows after the window
	// no longer blocks the flag, so a late short still reports overcurrent
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oc_cnt_r <= {CNT_W{1'b0}};
			oc_flag_r <= 1'b0;
		end else begin
			oc_cnt_r <= oc_s ? inc(oc_cnt_r) : {CNT_W{1'b0}};
			if (!cmd)
				oc_flag_r <= 1'b0;
			else if (oc_off && oc_win && !sc_latch_r)
				oc_flag_r <= 1'b1;
		end
	end

	// Command-low timer for the short latch clear, restarted by any high
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			low_cnt_r <= {CNT_W{1'b0}};
		else
			low_cnt_r <= cmd ? {CNT_W{1'b0}} : inc(low_cnt_r);
	end

	// Short latch; a new short in the clearing cycle wins over the clear.
	// Only a full low count or power loss (reset) releases the transistor
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			sc_latch_r <= 1'b0;
		else if (sc_s && !oc_win && !oc_flag_r)
			sc_latch_r <= 1'b1;
		else if (!cmd && reached(low_cnt_r, SCR))
			sc_latch_r <= 1'b0;
	end

	// Diode emulation state machine, active only with transistor hot
	always @* begin
		de_st_nxt = de_st_r;
		case (de_st_r)
			DE_BLANK: if (reached(blank_cnt_r, BLANK))
				de_st_nxt = DE_WATCH;
			DE_WATCH: if (ndrain)
				de_st_nxt = DE_ON;
			DE_ON: if (fwd)
				de_st_nxt = DE_WATCH;
			default: de_st_nxt = DE_WATCH;
		endcase
		// A command fall restarts blanking from any state
		if (cmd_fall)
			de_st_nxt = DE_BLANK;
		// Outside transistor heat, or in driver heat, park in the watch state
		if (!fhot || dhot)
			de_st_nxt = DE_WATCH;
	end

	// State register and blanking timer, timer held at zero outside blanking
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			de_st_r <= DE_WATCH;
			blank_cnt_r <= {CNT_W{1'b0}};
		end else begin
			de_st_r <= de_st_nxt;
			blank_cnt_r <= (de_st_nxt == DE_BLANK && !cmd_fall) ?
				inc(blank_cnt_r) : {CNT_W{1'b0}};
		end
	end

	// Strap sampled once, on the first edge at which the synchroniser holds
	// a real pin level; its reset value would read as a grounded strap
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_r <= 1'b0;
			combined_mode_r <= 1'b0;
		end else if (!strap_done_r && settled) begin
			strap_done_r <= 1'b1;
			combined_mode_r <= ~ocpin;
		end
	end

	// Rails: on at supply-good rising edge, off in lockout or driver heat,
	// and back on once the driver cools with the supply still good
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			rails_r <= 1'b0;
		else if (lockout || dhot)
			rails_r <= 1'b0;
		else if ((sgood && !sgood_d_r) || (!dhot && rails_r == 1'b0 && sgood))
			rails_r <= 1'b1;
	end

	// Reporting classes and gate blocking shared by the output registers
	wire report_fault = !ser_on || lockout || hot || dopen;
	wire gate_block = lockout || dhot || sc_latch_r || !ser_on;

	// Transistor gate; protection acts however the outputs are wired,
	// even with nobody watching them
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			fet_on_r <= 1'b0;
		else if (gate_block)
			fet_on_r <= 1'b0;
		else if (fhot)
			fet_on_r <= (de_st_r == DE_ON);
		else
			fet_on_r <= cmd && !oc_flag_r && !oc_off;
	end

	// Slowed drive follows the short latch, so its turn-off is gentle
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			drive_sel_r <= `SW_NORMAL;
		else
			drive_sel_r <= sc_latch_r ? `SW_SOFT : `SW_NORMAL;
	end

	// Rail enables, one register stage after the rail decision
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aux_regulator_en_r <= 1'b0;
			negative_rail_en_r <= 1'b0;
		end else begin
			aux_regulator_en_r <= rails_r;
			negative_rail_en_r <= rails_r;
		end
	end

	// Fault output: low for every fault class except plain overcurrent,
	// which combined mode adds as well
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			fault_n_r <= 1'b0;
		else if (report_fault || sc_latch_r)
			fault_n_r <= 1'b0;
		else
			fault_n_r <= ~(combined_mode_r & oc_flag_r);
	end

	// Overcurrent output: low for overcurrent or short, idles high,
	// and stays high in combined mode where nobody reads it
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			overcurrent_status_n_r <= 1'b1;
		else
			overcurrent_status_n_r <= combined_mode_r ? 1'b1 :
				~(oc_flag_r | sc_latch_r);
	end

	// Push-pull enables; the overcurrent pin floats until the strap is read,
	// since driving it earlier would fight a grounded strap
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_oe_r <= 1'b1;
			overcurrent_status_oe_r <= 1'b0;
		end else begin
			fault_oe_r <= 1'b1;
			overcurrent_status_oe_r <= strap_done_r && !combined_mode_r;
		end
	end
endmodule // power_switch_fault_protect
`default_nettype wire

// ---- bench/pfp_asserts.sv ----
// Checker of the switch fault protection ports
`timescale 1ns/1ps
`default_nettype none
module pfp_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic gate_cmd,
	input wire logic oc_cmp,
	input wire logic sc_cmp,
	input wire logic fet_hot,
	input wire logic drv_hot,
	input wire logic supply_good,
	input wire logic series_on,
	input wire logic drive_open,
	input wire logic neg_drain,
	input wire logic fwd_current,
	input wire logic oc_pin_in,
	input wire logic fet_on_r,
	input wire logic [1:0] drive_sel_r,
	input wire logic aux_regulator_en_r,
	input wire logic negative_rail_en_r,
	input wire logic fault_n_r,
	input wire logic fault_oe_r,
	input wire logic overcurrent_status_n_r,
	input wire logic overcurrent_status_oe_r,
	input wire logic combined_mode_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Counts cover the synchronizer plus the turn-off delay
	a_oc_trip: assert property ((gate_cmd && oc_cmp)[*8] |-> !fet_on_r)
		else $error("no overcurrent turn-off");
	a_oc_flag: assert property ((gate_cmd && oc_cmp && !combined_mode_r)[*8]
		|-> !overcurrent_status_n_r) else $error("no oc flag");
	a_lockout_off: assert property ((!supply_good)[*5] |-> !fet_on_r && !fault_n_r)
		else $error("lockout ignored");
	a_drv_hot: assert property (drv_hot[*5] |-> !fet_on_r && !aux_regulator_en_r
		&& !negative_rail_en_r) else $error("driver heat ignored");
	a_hot_fault: assert property ((fet_hot || drv_hot)[*5] |-> !fault_n_r)
		else $error("no thermal fault");
	a_startup_low: assert property ((!series_on)[*5] |-> !fault_n_r)
		else $error("fault high at start-up");
	a_push_pull: assert property (fault_oe_r && $stable(fault_oe_r))
		else $error("fault not driven");
	a_rails_up: assert property ($rose(supply_good) ##1 (supply_good && !drv_hot)[*4]
		|-> aux_regulator_en_r && negative_rail_en_r) else $error("rails off");
	a_short_off: assert property (drive_sel_r == 2'h1 |-> !fet_on_r)
		else $error("on while short latched");
	a_oc_unused: assert property (combined_mode_r |-> overcurrent_status_n_r
		&& !overcurrent_status_oe_r) else $error("oc pin used in combined mode");
	cover property (!fault_n_r && !overcurrent_status_n_r);
	cover property (fet_hot && fet_on_r);
	cover property ($rose(aux_regulator_en_r));
	cover property (combined_mode_r && !fault_n_r);
endmodule // pfp_asserts
bind power_switch_fault_protect pfp_asserts u_chk (.*);
`default_nettype wire

// ---- bench/ctrl_model.sv ----
// Converter controller model driving the gate command
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	input wire logic mclk,
	input wire logic [1:0] mode,
	input wire logic [3:0] on_len,
	output logic gate_cmd = 1'b0
);
	logic [3:0] ph_r = 4'h0;
	// Mode 0 holds low long enough to clear a latched short
	always @(posedge mclk) begin
		ph_r <= ph_r + 4'h1;
		gate_cmd <= #1 (mode == 2'h1) || (mode == 2'h2 && ph_r < on_len);
	end
endmodule // ctrl_model
`default_nettype wire

// ---- bench/power_switch_fault_protect_tb_top.sv ----
// Self-checking bench of the switch fault protection block
`timescale 1ns/1ps
`default_nettype none
module power_switch_fault_protect_tb_top;
	logic mclk = 0, rst_n = 0, oc = 0, sc = 0, fh = 0, dh = 0, sg = 1, so = 0;
	logic op = 1, dop = 0;
	logic nd = 0, fc = 0, smp = 0, gate, fet, aux, neg, fn, foe, ocn, ocoe, cmb;
	logic [1:0] mode = 2'h0, dsel;
	logic [3:0] len = 4'h8;
	logic [5:0] q[$];
	logic [31:0] rs = 32'h2d;
	int fails = 0, cmp_count = 0, cyc = 0;
	always #10 mclk = ~mclk;
	ctrl_model u_ctrl (.mclk(mclk), .mode(mode), .on_len(len), .gate_cmd(gate));
	power_switch_fault_protect #(.SC_RESET_CYCLES(8)) dut (.mclk(mclk),
		.rst_n(rst_n), .gate_cmd(gate), .oc_cmp(oc), .sc_cmp(sc), .fet_hot(fh),
		.drv_hot(dh), .supply_good(sg), .series_on(so), .drive_open(dop),
		.neg_drain(nd), .fwd_current(fc), .oc_pin_in(op), .fet_on_r(fet),
		.drive_sel_r(dsel), .aux_regulator_en_r(aux), .negative_rail_en_r(neg),
		.fault_n_r(fn), .fault_oe_r(foe), .overcurrent_status_n_r(ocn),
		.overcurrent_status_oe_r(ocoe), .combined_mode_r(cmb));
	function logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Let the synchronizer settle, then leave a note for the watcher
	task chk(input logic [5:0] x);
		step(8);
		q.push_back(x);
		smp = 1;
		step(1);
		smp = 0;
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Sampled on the falling edge, clear of the register updates
	always @(negedge mclk) if (smp) begin
		cmp_count++;
		if ({fet, fn, ocn, aux, dsel} !== q[0]) begin
			fails++;
			$display("FAIL %0t got %h want %h", $time, {fet, fn, ocn, aux, dsel}, q[0]);
		end
		// Rails match, fault pin always driven, strap picks the oc pin use
		cmp_count++;
		if ({neg, foe, ocoe, cmb} !==
			{q[0][2], 1'b1, op, ~op}) begin
			fails++;
			$display("FAIL %0t enables got %h", $time, {neg, foe, ocoe, cmb});
		end
		void'(q.pop_front());
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end
	// Bits: transistor, fault, overcurrent, rails, drive select
	initial begin
		step(4);
		rst_n = 1;
		chk(6'h0c);
		so = 1;
		chk(6'h1c);
		mode = 2'h1;
		chk(6'h3c);
		oc = 1;
		chk(6'h14);
		mode = 2'h0;
		chk(6'h1c);
		oc = 0;
		mode = 2'h1;
		chk(6'h3c);
		sc = 1;
		oc = 1;
		chk(6'h05);
		sc = 0;
		oc = 0;
		mode = 2'h0;
		step(3);
		mode = 2'h1;
		chk(6'h05);
		mode = 2'h0;
		step(6);
		chk(6'h1c);
		fh = 1;
		chk(6'h0c);
		nd = 1;
		chk(6'h2c);
		nd = 0;
		fc = 1;
		chk(6'h0c);
		fc = 0;
		dh = 1;
		nd = 1;
		chk(6'h08);
		dh = 0;
		chk(6'h2c);
		mode = 2'h1;
		step(4);
		mode = 2'h0;
		chk(6'h0c);
		fh = 0;
		nd = 0;
		chk(6'h1c);
		sg = 0;
		chk(6'h08);
		sg = 1;
		chk(6'h1c);
		oc = 1;
		mode = 2'h2;
		repeat (4) begin
			rs = xs(rs);
			len = rs[3:0] | 4'h8;
			step(20);
		end
		oc = 0;
		mode = 2'h0;
		chk(6'h1c);
		dop = 1;
		chk(6'h0c);
		dop = 0;
		// Grounded strap through a second reset selects combined reporting
		op = 0;
		rst_n = 0;
		step(4);
		rst_n = 1;
		chk(6'h1c);
		mode = 2'h1;
		oc = 1;
		chk(6'h0c);
		oc = 0;
		mode = 2'h0;
		chk(6'h1c);
		summarize();
	end
endmodule // power_switch_fault_protect_tb_top
`default_nettype wire
